// file: logic/dsa_indicator.sv
// drive status and alarm indicator with Avalon-MM register slave
// assumes drive status levels synchronous to clock; one clock domain
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module dsa_indicator #(
   parameter int OVERLOAD_CYCLES = dsa_pkg::OVERLOAD_CYCLES,
   parameter int BLINK_CYCLES    = dsa_pkg::BLINK_CYCLES
) (
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic [7:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   input  wire logic [3:0]            byteenable,
   output var  logic [31:0]           readdata,
   output var  logic                  waitrequest,
   input  wire dsa_pkg::dsa_drive_type drive,
   input  wire logic [15:0]           speed_rpm,
   input  wire logic [15:0]           pos_err,
   output var  logic                  led_green,
   output var  logic                  led_red,
   output var  logic                  irq
);

   if (OVERLOAD_CYCLES < 2 || BLINK_CYCLES < 2)
   begin : g_chk
      $error("dsa_indicator: timing parameters must be at least 2");
   end

   localparam logic [31:0] OVL_LAST   = 32'(OVERLOAD_CYCLES - 1);
   localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);

   typedef enum {
      SHOW_DISABLED,
      SHOW_ENABLED,
      SHOW_COMM,
      SHOW_MOVING,
      SHOW_DEVIATION,
      SHOW_ALARM
   } dsa_show_type;

   dsa_pkg::dsa_state_type s_r;
   dsa_pkg::dsa_state_type s_nxt;
   dsa_show_type           show;

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0]  be
   );
      logic [15:0] res;
      res = old;
      if (be[0])
      begin
         res[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   // lowest code wins when several trip in the same cycle
   function automatic logic [3:0] detect(
      input dsa_pkg::dsa_drive_type d,
      input logic [15:0] spd,
      input logic [15:0] perr,
      input logic        ovl_done,
      input logic [15:0] spd_lim,
      input logic [15:0] trk_lim,
      input logic [15:0] inp_lim,
      input logic [15:0] ovf_lim
   );
      logic [3:0] c;
      c = dsa_pkg::AL_NONE;
      if (d.overcurrent)
      begin
         c = dsa_pkg::AL_OCUR;                                   // [R7]
      end
      else if (spd > spd_lim)
      begin
         c = dsa_pkg::AL_OSPD;                                   // [R8]
      end
      else if (d.moving && perr > trk_lim)
      begin
         c = dsa_pkg::AL_TRK;                                    // [R9] [R18]
      end
      else if (ovl_done)
      begin
         c = dsa_pkg::AL_OVL;                                    // [R10]
      end
      else if (d.overtemp)
      begin
         c = dsa_pkg::AL_OTMP;                                   // [R11]
      end
      else if (d.regen_over)
      begin
         c = dsa_pkg::AL_REGN;                                   // [R12]
      end
      else if (d.motor_absent)
      begin
         c = dsa_pkg::AL_MOT;                                    // [R13]
      end
      else if (d.encoder_fault)
      begin
         c = dsa_pkg::AL_ENC;                                    // [R14]
      end
      else if (d.move_done && !d.moving && perr > inp_lim)
      begin
         c = dsa_pkg::AL_INP;                                    // [R15] [R18]
      end
      else if (d.tuning_error)
      begin
         c = dsa_pkg::AL_TUNE;                                   // [R16]
      end
      else if (!d.moving && perr > ovf_lim)
      begin
         c = dsa_pkg::AL_OVF;                                    // [R17] [R18]
      end
      return c;
   endfunction

   // display mode; an alarm masks every drive state
   always_comb
   begin
      if (s_r.alarm != dsa_pkg::AL_NONE)
      begin
         show = SHOW_ALARM;
      end
      else if (!drive.enabled)
      begin
         show = SHOW_DISABLED;
      end
      else if (drive.moving)
      begin
         show = SHOW_MOVING;
      end
      else if (drive.move_done && pos_err != 16'h0000)
      begin
         show = SHOW_DEVIATION;
      end
      else if (drive.comm_active)
      begin
         show = SHOW_COMM;
      end
      else
      begin
         show = SHOW_ENABLED;
      end
   end

   always_comb
   begin
      logic        take;
      logic        hit;
      logic        tick;
      logic        ovl_done;
      logic [3:0]  code;
      logic [5:0]  burst_end;
      logic [dsa_pkg::IRQ_W-1:0] ev;
      logic [dsa_pkg::IRQ_W-1:0] clr;
      take      = 1'b0;
      hit       = 1'b0;
      tick      = 1'b0;
      ovl_done  = 1'b0;
      code      = dsa_pkg::AL_NONE;
      burst_end = 6'h00;
      ev        = '0;
      clr       = '0;
      s_nxt     = s_r;

      // one-cycle waitrequest low per request; read data latched on first cycle, write taken while waitrequest is low
      take = (read || write) && !s_r.waitrequest;
      s_nxt.waitrequest = !((read || write) && s_r.waitrequest);
      if (read && s_r.waitrequest)
      begin
         unique case (address)
            dsa_pkg::ADDR_TRK_LIM: s_nxt.readdata = {16'h0000, s_r.trk_lim};
            dsa_pkg::ADDR_OVF_LIM: s_nxt.readdata = {16'h0000, s_r.ovf_lim};
            dsa_pkg::ADDR_INP_LIM: s_nxt.readdata = {16'h0000, s_r.inp_lim};
            dsa_pkg::ADDR_SPD_LIM: s_nxt.readdata = {16'h0000, s_r.spd_lim};
            dsa_pkg::ADDR_STATUS:
               s_nxt.readdata = {26'h0000000, s_r.led_red, s_r.led_green, s_r.alarm};
            dsa_pkg::ADDR_IRQ_STS: s_nxt.readdata = {30'h00000000, s_r.irq_sts};
            dsa_pkg::ADDR_IRQ_EN:  s_nxt.readdata = {30'h00000000, s_r.irq_en};
            default:               s_nxt.readdata = 32'h00000000;
         endcase
      end

      if (write && take)
      begin
         unique case (address)
            dsa_pkg::ADDR_TRK_LIM:
               s_nxt.trk_lim = merge16(s_r.trk_lim, writedata, byteenable);  // [R18]
            dsa_pkg::ADDR_OVF_LIM:
               s_nxt.ovf_lim = merge16(s_r.ovf_lim, writedata, byteenable);  // [R18]
            dsa_pkg::ADDR_INP_LIM:
               s_nxt.inp_lim = merge16(s_r.inp_lim, writedata, byteenable);
            dsa_pkg::ADDR_SPD_LIM:
               s_nxt.spd_lim = merge16(s_r.spd_lim, writedata, byteenable);
            dsa_pkg::ADDR_IRQ_CLR:
               clr = byteenable[0] ? writedata[dsa_pkg::IRQ_W-1:0] : '0;
            dsa_pkg::ADDR_IRQ_EN:
               if (byteenable[0])
               begin
                  s_nxt.irq_en = writedata[dsa_pkg::IRQ_W-1:0];
               end
            default: ;
         endcase
      end

      // overload timer restarts whenever the condition drops
      if (!drive.overload)
      begin
         s_nxt.ovl_cnt = 32'h00000000;                           // [R10]
      end
      else if (s_r.ovl_cnt != OVL_LAST)
      begin
         s_nxt.ovl_cnt = s_r.ovl_cnt + 32'h00000001;
      end
      ovl_done = drive.overload && s_r.ovl_cnt == OVL_LAST;

      // alarm latches until software clears it; a trip seen while latched is ignored and the clear still applies
      code = detect(drive, speed_rpm, pos_err, ovl_done, s_r.spd_lim,
                    s_r.trk_lim, s_r.inp_lim, s_r.ovf_lim);
      hit  = s_r.alarm == dsa_pkg::AL_NONE && code != dsa_pkg::AL_NONE;
      if (hit)
      begin
         s_nxt.alarm = code;
         ev[dsa_pkg::IRQ_RAISE_BIT] = 1'b1;
      end
      else if (write && take && address == dsa_pkg::ADDR_CTRL && byteenable[0]
               && writedata[dsa_pkg::CTRL_CLR_BIT] && s_r.alarm != dsa_pkg::AL_NONE)
      begin
         s_nxt.alarm = dsa_pkg::AL_NONE;
         ev[dsa_pkg::IRQ_CLEAR_BIT] = 1'b1;
      end

      // set beats clear on the sticky bits
      s_nxt.irq_sts = (s_r.irq_sts & ~clr) | ev;
      s_nxt.irq     = |(s_nxt.irq_sts & s_nxt.irq_en);

      // blink timebase: one step per half period
      tick = s_r.tick_cnt == BLINK_LAST;
      s_nxt.tick_cnt = tick ? 32'h00000000 : s_r.tick_cnt + 32'h00000001;
      if (tick)
      begin
         s_nxt.phase = !s_r.phase;
      end

      // burst: 2*code half steps then a dark gap, so bursts stay countable
      burst_end = {1'b0, s_r.alarm, 1'b0} + dsa_pkg::GAP_STEPS;      // [R19]
      if (show != SHOW_ALARM)
      begin
         s_nxt.step = 6'h00;
      end
      else if (tick)
      begin
         s_nxt.step = (s_r.step + 6'h01 >= burst_end) ? 6'h00 : s_r.step + 6'h01;
      end

      unique case (show)
         SHOW_DISABLED:
         begin
            s_nxt.led_green = s_r.phase;                         // [R1]
            s_nxt.led_red   = 1'b0;
         end
         SHOW_ENABLED:
         begin
            s_nxt.led_green = 1'b1;                              // [R2]
            s_nxt.led_red   = 1'b0;
         end
         SHOW_COMM:
         begin
            s_nxt.led_green = 1'b1;                              // [R3]
            s_nxt.led_red   = s_r.phase;
         end
         SHOW_MOVING:
         begin
            s_nxt.led_green = 1'b1;                              // [R4]
            s_nxt.led_red   = 1'b1;
         end
         SHOW_DEVIATION:
         begin
            s_nxt.led_green = s_r.phase;                         // [R5]
            s_nxt.led_red   = !s_r.phase;
         end
         SHOW_ALARM:
         begin
            s_nxt.led_green = 1'b0;
            s_nxt.led_red   = s_r.step < {1'b0, s_r.alarm, 1'b0}
                              && !s_r.step[0];                   // [R6] [R19]
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s_r             <= '0;
         s_r.waitrequest <= 1'b1;
         s_r.trk_lim     <= dsa_pkg::TRK_LIM_RST;
         s_r.ovf_lim     <= dsa_pkg::OVF_LIM_RST;
         s_r.inp_lim     <= dsa_pkg::INP_LIM_RST;
         s_r.spd_lim     <= dsa_pkg::SPD_LIM_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign readdata    = s_r.readdata;
   assign waitrequest = s_r.waitrequest;
   assign led_green   = s_r.led_green;
   assign led_red     = s_r.led_red;
   assign irq         = s_r.irq;

endmodule

`default_nettype wire

// file: logic/dsa_pkg.sv
// constants, register map and state carrier of the drive status indicator
// assumes a 100 MHz clock and an Avalon-MM master with byte addressing
//
// Overview of operation
// R1 - drive disabled: green blinks, red dark.
// R2 - enabled, no serial traffic: green steady, red dark.
// R3 - enabled with serial traffic: green steady, red blinks.
// R4 - motor moving: green and red both steady on.
// R5 - in-position deviation: green and red flash alternately, never together.
// R6 - alarm latched: red flashes bursts, pulse count equals alarm code.
// R7 - overcurrent detector trip raises alarm 1.
// R8 - measured speed above speed limit raises alarm 2.
// R9 - running with position error above tracking limit raises alarm 3.
// R10 - overload held over five seconds raises alarm 4; timer restarts on clear.
// R11 - over-temperature detector raises alarm 5.
// R12 - regeneration detector over voltage raises alarm 6.
// R13 - powered with no motor cable raises alarm 7.
// R14 - encoder cable fault raises alarm 8.
// R15 - position error after a completed move raises alarm 10.
// R16 - error during tuning raises alarm 12.
// R17 - stopped with position error above overflow limit raises alarm 15.
// R18 - limits come from writable registers, defaulting until overwritten.
// R19 - a longer dark gap separates consecutive alarm bursts.
`default_nettype none

package dsa_pkg;

   localparam int CLK_MHZ = 100;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_TRK_LIM  = 8'h04;
   localparam logic [7:0] ADDR_OVF_LIM  = 8'h08;
   localparam logic [7:0] ADDR_INP_LIM  = 8'h0C;
   localparam logic [7:0] ADDR_SPD_LIM  = 8'h10;
   localparam logic [7:0] ADDR_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STS  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h20;

   // fields
   localparam int CTRL_CLR_BIT  = 0;
   localparam int IRQ_RAISE_BIT = 0;
   localparam int IRQ_CLEAR_BIT = 1;
   localparam int IRQ_W         = 2;

   // reset values; limits in degrees, speed in rpm
   localparam logic [15:0] TRK_LIM_RST = 16'h005A;
   localparam logic [15:0] OVF_LIM_RST = 16'h005A;
   localparam logic [15:0] INP_LIM_RST = 16'h000A;
   localparam logic [15:0] SPD_LIM_RST = 16'h0BB8;

   // alarm codes shown as burst lengths
   localparam logic [3:0] AL_NONE = 4'h0;
   localparam logic [3:0] AL_OCUR = 4'h1;
   localparam logic [3:0] AL_OSPD = 4'h2;
   localparam logic [3:0] AL_TRK  = 4'h3;
   localparam logic [3:0] AL_OVL  = 4'h4;
   localparam logic [3:0] AL_OTMP = 4'h5;
   localparam logic [3:0] AL_REGN = 4'h6;
   localparam logic [3:0] AL_MOT  = 4'h7;
   localparam logic [3:0] AL_ENC  = 4'h8;
   localparam logic [3:0] AL_INP  = 4'hA;
   localparam logic [3:0] AL_TUNE = 4'hC;
   localparam logic [3:0] AL_OVF  = 4'hF;

   // timing
   localparam int OVERLOAD_TIME_MS = 5000;
   localparam int OVERLOAD_CYCLES  = OVERLOAD_TIME_MS * 1000 * CLK_MHZ;
   localparam int BLINK_TIME_MS    = 250;
   localparam int BLINK_CYCLES     = BLINK_TIME_MS * 1000 * CLK_MHZ;
   localparam logic [5:0] GAP_STEPS = 6'h06;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
      logic [15:0] trk_lim;
      logic [15:0] ovf_lim;
      logic [15:0] inp_lim;
      logic [15:0] spd_lim;
      logic [3:0]  alarm;
      logic [31:0] ovl_cnt;
      logic [31:0] tick_cnt;
      logic [5:0]  step;
      logic        phase;
      logic        led_green;
      logic        led_red;
      logic [IRQ_W-1:0] irq_sts;
      logic [IRQ_W-1:0] irq_en;
      logic        irq;
   } dsa_state_type;

   typedef struct packed {
      logic        enabled;
      logic        comm_active;
      logic        moving;
      logic        move_done;
      logic        overcurrent;
      logic        overload;
      logic        overtemp;
      logic        regen_over;
      logic        motor_absent;
      logic        encoder_fault;
      logic        tuning_error;
   } dsa_drive_type;

endpackage

`default_nettype wire

// file: test/dsa_indicator_checker.sv
// port checker for the drive status indicator
// bound to dsa_indicator; single clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module dsa_indicator_checker (
   input  wire logic                   clock,
   input  wire logic                   reset,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic                   waitrequest,
   input  wire dsa_pkg::dsa_drive_type drive,
   input  wire logic [15:0]            pos_err,
   input  wire logic                   led_green,
   input  wire logic                   led_red
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (reset);

   chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request left without answer");
   chk_bus_single: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   chk_bus_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
      else $error("answer without a request");
   // green lit means no alarm was showing, so the state display applies
   chk_moving_both: assert property (
      $past(drive.enabled && drive.moving) && led_green |-> led_red)
      else $error("red dark while moving");
   chk_enabled_quiet: assert property (
      $past(drive.enabled && !drive.comm_active && !drive.moving && !drive.move_done)
      && led_green |-> !led_red)
      else $error("red lit while enabled and idle");
   chk_disabled_red: assert property (
      $past(!drive.enabled) && led_green |-> !led_red)
      else $error("red lit while disabled");
   chk_deviation_alt: assert property (
      $past(drive.enabled && drive.move_done && !drive.moving && pos_err != 16'h0000)
      |-> !(led_green && led_red))
      else $error("both lit during deviation");
   chk_alarm_green: assert property (
      $past(!drive.moving && !drive.comm_active && !drive.move_done) && led_red
      |-> !led_green)
      else $error("green lit during alarm burst");
endmodule

bind dsa_indicator dsa_indicator_checker dsa_indicator_checker_i (
   .clock       (clock),
   .reset       (reset),
   .read        (read),
   .write       (write),
   .waitrequest (waitrequest),
   .drive       (drive),
   .pos_err     (pos_err),
   .led_green   (led_green),
   .led_red     (led_red)
);
`default_nettype wire

// file: test/tb_drive_status_alarm_indicator.sv
// self-checking bench for the drive status indicator
// shortened counts: overload 20 cycles, blink 4 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_drive_status_alarm_indicator;
   logic                   clock = 1'b0;
   logic                   reset = 1'b1;
   logic [7:0]             address = 8'h00;
   logic                   read = 1'b0;
   logic                   write = 1'b0;
   logic [31:0]            writedata = 32'h0;
   logic [3:0]             byteenable = 4'hF;
   logic [31:0]            readdata;
   logic                   waitrequest;
   dsa_pkg::dsa_drive_type drive = '0;
   logic [15:0]            speed_rpm = 16'h0000;
   logic [15:0]            pos_err = 16'h0000;
   logic                   led_green;
   logic                   led_red;
   logic                   irq;
   logic [31:0]            rd;
   logic [31:0]            st;
   int                     err_count = 0;
   int                     checks = 0;
   int                     gtg, rtg, same, maxd;
   logic                   g, r;

   dsa_indicator #(.OVERLOAD_CYCLES(20), .BLINK_CYCLES(4)) dsa_indicator_i (
      .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .drive(drive), .speed_rpm(speed_rpm), .pos_err(pos_err),
      .led_green(led_green), .led_red(led_red), .irq(irq));

   always #5 clock = ~clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // values sampled right after an edge are those the edge saw
   // no local limit: only the watchdog ends a wait that never gets its answer
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      @(posedge clock);
      while (waitrequest !== 1'b0)
      begin
         @(posedge clock);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic raise(input logic [10:0] d, input logic [15:0] pe, input logic [15:0] spd,
                        input int hold);
      drive <= dsa_pkg::dsa_drive_type'(d);
      pos_err <= pe;
      speed_rpm <= spd;
      tick(hold);
      drive <= dsa_pkg::dsa_drive_type'(11'h400);
      pos_err <= 16'h0000;
      speed_rpm <= 16'h0000;
      tick(2);
      bus(0, dsa_pkg::ADDR_STATUS, 32'h0);
      st = rd & 32'h0000000F;
      bus(1, dsa_pkg::ADDR_CTRL, 32'h1);
   endtask

   task automatic show(input logic [10:0] d, input logic [15:0] pe, input int n);
      int cur;
      drive <= dsa_pkg::dsa_drive_type'(d);
      pos_err <= pe;
      tick(3);
      g = led_green;
      r = led_red;
      gtg = 0;
      rtg = 0;
      same = 0;
      maxd = 0;
      cur = 0;
      repeat (n)
      begin
         @(posedge clock);
         gtg += int'(led_green !== g);
         rtg += int'(led_red !== r);
         same += int'(led_green === led_red);
         cur = led_red ? 0 : cur + 1;
         maxd = (cur > maxd) ? cur : maxd;
         g = led_green;
         r = led_red;
      end
   endtask

   task automatic test_regs;
      bus(0, dsa_pkg::ADDR_TRK_LIM, 32'h0);
      check(rd, 32'h0000005A);
      bus(0, dsa_pkg::ADDR_OVF_LIM, 32'h0);
      check(rd, 32'h0000005A);
      bus(0, 8'h40, 32'h0);
      check(rd, 32'h0);
      bus(1, dsa_pkg::ADDR_TRK_LIM, 32'hFFFF00C8);
      bus(0, dsa_pkg::ADDR_TRK_LIM, 32'h0);
      check(rd, 32'h000000C8);
      raise(11'h500, 16'h0096, 16'h0000, 3);
      check(st, 32'h0);
      raise(11'h500, 16'h00C9, 16'h0000, 3);
      check(st, 32'h3);
      bus(1, dsa_pkg::ADDR_TRK_LIM, 32'h0000005A);
   endtask

   task automatic test_irq;
      bus(1, dsa_pkg::ADDR_IRQ_CLR, 32'h3);
      raise(11'h410, 16'h0000, 16'h0000, 3);
      bus(1, dsa_pkg::ADDR_IRQ_CLR, 32'h2);
      // clearing the cleared-event bit must leave the raise bit pending
      bus(0, dsa_pkg::ADDR_IRQ_STS, 32'h0);
      check(rd, 32'h1);
      check({31'h0, irq}, 32'h0);
      bus(1, dsa_pkg::ADDR_IRQ_EN, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h1);
      bus(1, dsa_pkg::ADDR_IRQ_CLR, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h0);
      bus(0, dsa_pkg::ADDR_IRQ_CLR, 32'h0);
      check(rd, 32'h0);
      bus(1, dsa_pkg::ADDR_IRQ_EN, 32'h0);
   endtask

   task automatic test_alarms;
      raise(11'h440, 16'h0000, 16'h0000, 3);
      check(st, 32'h1);
      raise(11'h400, 16'h0000, 16'h0BB8, 3);
      check(st, 32'h0);
      raise(11'h400, 16'h0000, 16'h0BB9, 3);
      check(st, 32'h2);
      raise(11'h500, 16'h005A, 16'h0000, 3);
      check(st, 32'h0);
      raise(11'h500, 16'h005B, 16'h0000, 3);
      check(st, 32'h3);
      raise(11'h420, 16'h0000, 16'h0000, 15);
      raise(11'h420, 16'h0000, 16'h0000, 15);
      check(st, 32'h0);
      raise(11'h420, 16'h0000, 16'h0000, 25);
      check(st, 32'h4);
      raise(11'h410, 16'h0000, 16'h0000, 3);
      check(st, 32'h5);
      raise(11'h408, 16'h0000, 16'h0000, 3);
      check(st, 32'h6);
      raise(11'h404, 16'h0000, 16'h0000, 3);
      check(st, 32'h7);
      raise(11'h402, 16'h0000, 16'h0000, 3);
      check(st, 32'h8);
      raise(11'h480, 16'h000B, 16'h0000, 3);
      check(st, 32'hA);
      raise(11'h401, 16'h0000, 16'h0000, 3);
      check(st, 32'hC);
      raise(11'h400, 16'h005B, 16'h0000, 3);
      check(st, 32'hF);
   endtask

   task automatic test_leds;
      show(11'h000, 16'h0000, 32);
      check(32'(gtg), 32'd8);
      check(32'(rtg), 32'd0);
      check({31'h0, r}, 32'h0);
      show(11'h400, 16'h0000, 32);
      check(32'(gtg), 32'd0);
      check(32'(rtg), 32'd0);
      check({30'h0, g, r}, 32'h2);
      show(11'h600, 16'h0000, 32);
      check(32'(gtg), 32'd0);
      check(32'(rtg), 32'd8);
      check({31'h0, g}, 32'h1);
      show(11'h500, 16'h0000, 32);
      check(32'(gtg), 32'd0);
      check(32'(rtg), 32'd0);
      check({30'h0, g, r}, 32'h3);
      show(11'h480, 16'h0005, 32);
      check(32'(gtg), 32'd8);
      check(32'(same), 32'd0);
      drive <= dsa_pkg::dsa_drive_type'(11'h500);
      pos_err <= 16'h005B;
      tick(3);
      // two full periods of a code-3 burst
      show(11'h400, 16'h0000, 96);
      check(32'(gtg), 32'd0);
      check(32'(rtg), 32'd12);
      check({31'h0, g}, 32'h0);
      check(maxd, 32'd28);
      bus(1, dsa_pkg::ADDR_CTRL, 32'h1);
   endtask

   task automatic give_verdict;
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      give_verdict;
   end

   initial
   begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      test_regs;
      test_irq;
      test_alarms;
      test_leds;
      give_verdict;
   end
endmodule
`default_nettype wire
